/* File: cbt_pkg.sv */
// Package with constants and types for the CAN transmit history and block transmission block.
package cbt_pkg;
	// Number of buffers in the block transmission group (buffers 0..7).
	localparam int BLOCK_COUNT = 8;
	// Width of a message buffer number.
	localparam int BUF_W = 4;
	// Depth of the transmit history list.
	localparam int HIST_DEPTH = 8;
	// Depth of the completion FIFO in front of the history list.
	localparam int FIFO_DEPTH = 4;
	// First buffer of a block run after a restart.
	localparam logic [3:0] FIRST_BUF = 4'h0;
	// Reset value of the empty flag.
	localparam logic EMPTY_RESET = 1'b1;
	// States of the block transmission engine.
	typedef enum logic [1:0] {CBT_IDLE, CBT_REQ, CBT_WAIT, CBT_CLEAR} cbt_state_t;
endpackage

/* File: cbt_fifo.sv */
// Small FIFO carrying completed buffer numbers towards the history list.
`timescale 1ns/1ps
module cbt_fifo #(
	parameter int WIDTH = 4,
	parameter int DEPTH = 4
) (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	// Storage array.
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] rd_ptr, wr_ptr, next_rd_ptr, next_wr_ptr;
	logic [AW:0] count, next_count;
	logic push, pop;

	// Steps a pointer by one slot, wrapping at the last slot.
	function automatic logic [AW-1:0] ptr_next(input logic [AW-1:0] ptr);
		return (ptr == AW'(DEPTH - 1)) ? '0 : ptr + AW'(1);
	endfunction

	// Handshakes.
	always_comb begin
		in_ready = (count != (AW+1)'(DEPTH)) ? 1'b1 : 1'b0;
		out_valid = (count != '0);
		push = in_valid && in_ready;
		pop = out_valid && out_ready;
		next_wr_ptr = push ? ptr_next(wr_ptr) : wr_ptr;
		next_rd_ptr = pop ? ptr_next(rd_ptr) : rd_ptr;
		next_count = count + (AW+1)'(push) - (AW+1)'(pop);
	end

	// Pointers and fill level.
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			rd_ptr <= '0;
			wr_ptr <= '0;
			count <= '0;
		end else begin
			rd_ptr <= next_rd_ptr;
			wr_ptr <= next_wr_ptr;
			count <= next_count;
		end
	end

	// The array has no reset; only valid slots are ever read.
	always_ff @(posedge clk) begin
		if (push) begin
			mem[wr_ptr] <= in_data;
		end
	end

	// Head word is read straight from the array.
	assign out_data = mem[rd_ptr];
endmodule

/* File: cbt_top.sv */
// Transmit history list and automatic block transmission engine.
`timescale 1ns/1ps
module cbt_top #(
	parameter int HIST_DEPTH = cbt_pkg::HIST_DEPTH,
	parameter int BLOCK_COUNT = cbt_pkg::BLOCK_COUNT
) (
	input wire logic CLK,
	input wire logic RESET_N,
	input wire logic BLOCK_TX_TRIGGER,
	input wire logic BLOCK_TX_RESTART_SET,
	output logic BLOCK_TX_RESTART,
	output logic TX_REQUEST_VALID,
	output logic [3:0] TX_REQUEST_BUF,
	input wire logic TX_DONE,
	input wire logic [3:0] TX_DONE_BUF,
	output logic TX_DONE_READY,
	input wire logic HIST_READ,
	output logic [3:0] HIST_DATA,
	output logic TX_HISTORY_EMPTY,
	output logic TX_HISTORY_OVERFLOW,
	input wire logic OVERFLOW_CLEAR
);
	localparam int HAW = $clog2(HIST_DEPTH);
	// History storage.
	logic [3:0] hist [HIST_DEPTH];
	logic [HAW-1:0] h_rd, h_wr, next_h_rd, next_h_wr;
	logic [HAW:0] h_cnt, next_h_cnt;
	logic ovf, next_ovf, empty, next_empty;
	logic f_valid, f_ready, h_push, h_pop;
	logic [3:0] f_data;
	// Engine state.
	cbt_pkg::cbt_state_t state, next_state;
	logic [3:0] cur, next_cur;
	logic restart, next_restart;

	// Completions queue up here so a burst of done pulses is not lost.
	// The list side drains it every cycle, so its ready only drops if completions pile up.
	cbt_fifo #(.WIDTH(4), .DEPTH(cbt_pkg::FIFO_DEPTH)) u_fifo (
		.clk(CLK),
		.reset_n(RESET_N),
		.in_valid(TX_DONE),
		.in_ready(TX_DONE_READY),
		.in_data(TX_DONE_BUF),
		.out_valid(f_valid),
		.out_ready(f_ready),
		.out_data(f_data)
	);

	// Advances a history pointer by one slot, wrapping at the list's end.
	// The explicit wrap keeps depths that are not a power of two working.
	function automatic logic [HAW-1:0] hist_next(input logic [HAW-1:0] ptr);
		return (ptr == HAW'(HIST_DEPTH - 1)) ? '0 : ptr + HAW'(1);
	endfunction

	// History list next state. The FIFO drains one entry a cycle always.
	always_comb begin
		f_ready = 1'b1;
		h_pop = HIST_READ && (h_cnt != '0);
		// A completion is dropped, not stored, once the list is in overflow.
		h_push = f_valid && !ovf && (h_cnt != (HAW+1)'(HIST_DEPTH) || h_pop);
		next_h_rd = h_pop ? hist_next(h_rd) : h_rd;
		next_h_wr = h_push ? hist_next(h_wr) : h_wr;
		next_h_cnt = h_cnt + (HAW+1)'(h_push) - (HAW+1)'(h_pop);
		next_ovf = ovf;
		// A full list with no room turns an entry into an overflow; set wins over clear.
		if (f_valid && !ovf && !h_push) begin
			next_ovf = 1'b1;
		end else if (OVERFLOW_CLEAR) begin
			next_ovf = 1'b0;
		end
		next_empty = (next_h_cnt == '0);
		// While overflowed, a new completion never clears the empty flag.
		if (ovf && empty) begin
			next_empty = 1'b1;
		end
		if (h_push) begin
			next_empty = 1'b0;
		end
	end

	// History registers.
	always_ff @(posedge CLK) begin
		if (!RESET_N) begin
			h_rd <= '0;
			h_wr <= '0;
			h_cnt <= '0;
			ovf <= 1'b0;
			empty <= cbt_pkg::EMPTY_RESET;
		end else begin
			h_rd <= next_h_rd;
			h_wr <= next_h_wr;
			h_cnt <= next_h_cnt;
			ovf <= next_ovf;
			empty <= next_empty;
		end
	end

	// History array and read data register.
	always_ff @(posedge CLK) begin
		if (h_push) begin
			hist[h_wr] <= f_data;
		end
		if (!RESET_N) begin
			HIST_DATA <= 4'h0;
		end else if (h_pop) begin
			HIST_DATA <= hist[h_rd];
		end
	end

	// Block engine next state. A restart is only honoured with the trigger low.
	// Dropping the trigger keeps the current buffer, so a later run resumes there.
	always_comb begin
		next_state = state;
		next_cur = cur;
		next_restart = restart;
		if (BLOCK_TX_RESTART_SET && !BLOCK_TX_TRIGGER) begin
			next_restart = 1'b1;
		end
		case (state)
			cbt_pkg::CBT_IDLE: begin
				if (restart) begin
					next_state = cbt_pkg::CBT_CLEAR;
				end else if (BLOCK_TX_TRIGGER) begin
					next_state = cbt_pkg::CBT_REQ;
				end
			end
			cbt_pkg::CBT_REQ: begin
				// One request pulse, then wait for its completion.
				next_state = cbt_pkg::CBT_WAIT;
			end
			cbt_pkg::CBT_WAIT: begin
				if (TX_DONE && TX_DONE_BUF == cur) begin
					// Step upward through the group, wrapping at its end.
					next_cur = (cur == 4'(BLOCK_COUNT - 1)) ? cbt_pkg::FIRST_BUF : cur + 4'h1;
					next_state = BLOCK_TX_TRIGGER ? cbt_pkg::CBT_REQ : cbt_pkg::CBT_IDLE;
				end else if (!BLOCK_TX_TRIGGER) begin
					next_state = cbt_pkg::CBT_IDLE;
				end
			end
			cbt_pkg::CBT_CLEAR: begin
				next_cur = cbt_pkg::FIRST_BUF;
				next_restart = 1'b0;
				next_state = cbt_pkg::CBT_IDLE;
			end
			default: begin
				next_state = cbt_pkg::CBT_IDLE;
			end
		endcase
	end

	// Engine registers.
	always_ff @(posedge CLK) begin
		if (!RESET_N) begin
			state <= cbt_pkg::CBT_IDLE;
			cur <= cbt_pkg::FIRST_BUF;
			restart <= 1'b0;
		end else begin
			state <= next_state;
			cur <= next_cur;
			restart <= next_restart;
		end
	end

	// Outputs. Requests come only from the engine.
	// Flags come straight from their registers, so they never glitch.
	assign TX_REQUEST_VALID = (state == cbt_pkg::CBT_REQ);
	assign TX_REQUEST_BUF = cur;
	assign BLOCK_TX_RESTART = restart;
	assign TX_HISTORY_EMPTY = empty;
	assign TX_HISTORY_OVERFLOW = ovf;

	// Checks on the history flags.
	// Overflow holds until cleared.
	a_ovf_hold: assert property (@(posedge CLK) disable iff (!RESET_N)
		ovf && !OVERFLOW_CLEAR |=> ovf) else $error("overflow dropped without clear");
	// A completion that meets a full list, with no read to make room, sets overflow.
	a_ovf_set: assert property (@(posedge CLK) disable iff (!RESET_N)
		f_valid && !ovf && h_cnt == (HAW+1)'(HIST_DEPTH) && !HIST_READ |=> ovf) else $error("full list kept quiet");
	// Empty stays set in overflow.
	a_empty_stuck: assert property (@(posedge CLK) disable iff (!RESET_N)
		ovf && empty |=> empty) else $error("empty cleared during overflow");
	// Reads possible while overflowed and not empty.
	a_read_ovf: assert property (@(posedge CLK) disable iff (!RESET_N)
		ovf && HIST_READ && h_cnt != '0 |=> h_cnt == $past(h_cnt) - 1'b1) else $error("read blocked");
	// Push clears empty.
	a_push_empty: assert property (@(posedge CLK) disable iff (!RESET_N)
		h_push |=> !empty) else $error("empty not cleared");
	// Checks on the block engine.
	// Restart rewinds to buffer zero two cycles after it is taken.
	a_restart_zero: assert property (@(posedge CLK) disable iff (!RESET_N)
		restart && state == cbt_pkg::CBT_IDLE |=> ##1 (cur == cbt_pkg::FIRST_BUF && !restart))
		else $error("restart did not rewind");
	// A restart written while the trigger is high is ignored.
	a_restart_refused: assert property (@(posedge CLK) disable iff (!RESET_N)
		BLOCK_TX_TRIGGER && !restart |=> !restart) else $error("restart taken with trigger high");
	// Restart bit clears itself.
	a_restart_self: assert property (@(posedge CLK) disable iff (!RESET_N)
		restart && state == cbt_pkg::CBT_CLEAR |=> !restart) else $error("restart stuck");
	// Requests ascend by one.
	a_req_order: assert property (@(posedge CLK) disable iff (!RESET_N)
		state == cbt_pkg::CBT_WAIT && TX_DONE && TX_DONE_BUF == cur && cur != 4'(BLOCK_COUNT - 1)
		|=> cur == $past(cur) + 4'h1) else $error("block order broken");
	// A request stands for exactly one cycle, so the far side never takes it twice.
	a_req_pulse: assert property (@(posedge CLK) disable iff (!RESET_N)
		TX_REQUEST_VALID |=> !TX_REQUEST_VALID) else $error("request longer than one cycle");
	// No request while idle.
	a_idle_quiet: assert property (@(posedge CLK) disable iff (!RESET_N)
		!BLOCK_TX_TRIGGER [*2] |-> !TX_REQUEST_VALID) else $error("request without trigger");
	// Main scenarios: a request followed by a completion, an overflow, a restart and a wrap at the group's end.
	c_run: cover property (@(posedge CLK) TX_REQUEST_VALID ##[1:50] TX_DONE);
	c_ovf: cover property (@(posedge CLK) ovf && empty);
	c_restart: cover property (@(posedge CLK) state == cbt_pkg::CBT_CLEAR);
	c_wrap: cover property (@(posedge CLK) state == cbt_pkg::CBT_WAIT && TX_DONE && cur == 4'(BLOCK_COUNT - 1));
endmodule

/* File: cbt_bus_model.sv */
// Far-side model: another CAN node that answers each transmit request with a completion.
`timescale 1ns/1ps
module cbt_bus_model (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic req_valid,
	input wire logic [3:0] req_buf,
	input wire logic done_ready,
	input wire logic [7:0] delay,
	output logic done,
	output logic [3:0] done_buf
);
	// Cycles left before the frame on the bus ends; zero while idle.
	int wait_left = 0;
	// Buffer whose frame is on the bus.
	logic [3:0] cur = 4'h0;
	// A completion is held until the list side takes it, then the number line is scrambled.
	always @(posedge clk) begin
		if (!reset_n) begin
			wait_left <= 0;
			done <= 1'b0;
			done_buf <= 4'hf;
		end else if (req_valid) begin
			cur <= req_buf;
			wait_left <= delay + 1;
		end else if (done && done_ready) begin
			done <= 1'b0;
			done_buf <= ~cur;
		end else if (wait_left == 1) begin
			done <= 1'b1;
			done_buf <= cur;
			wait_left <= 0;
		end else if (wait_left > 1) begin
			wait_left <= wait_left - 1;
		end
	end
endmodule

/* File: testbench.sv */
// Self-checking testbench for the transmit history list and block transmission engine.
`timescale 1ns/1ps
module testbench;
	logic CLK = 1'b0, RESET_N = 1'b0, TRIG = 1'b0, RSET = 1'b0, HRD = 1'b0, OCLR = 1'b0;
	logic REQV, RST, DRDY, DONE, EMPTY, OVF;
	logic [3:0] REQB, DBUF, HDATA;
	logic [7:0] delay = 8'h05;
	int num_errors = 0, total_checks = 0;
	int i;
	// The clock toggles every half period of 12.5 ns.
	always #12.5 CLK = ~CLK;
	cbt_top dut (.CLK(CLK), .RESET_N(RESET_N), .BLOCK_TX_TRIGGER(TRIG), .BLOCK_TX_RESTART_SET(RSET),
		.BLOCK_TX_RESTART(RST), .TX_REQUEST_VALID(REQV), .TX_REQUEST_BUF(REQB), .TX_DONE(DONE),
		.TX_DONE_BUF(DBUF), .TX_DONE_READY(DRDY), .HIST_READ(HRD), .HIST_DATA(HDATA),
		.TX_HISTORY_EMPTY(EMPTY), .TX_HISTORY_OVERFLOW(OVF), .OVERFLOW_CLEAR(OCLR));
	cbt_bus_model node (.clk(CLK), .reset_n(RESET_N), .req_valid(REQV), .req_buf(REQB), .done_ready(DRDY),
		.delay(delay), .done(DONE), .done_buf(DBUF));
	// Compares one seen value with its expectation and counts the result.
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		total_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	// Prints the counts and the verdict, then ends the run.
	task automatic test_done;
		$display("checks=%0d errors=%0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	// Waits a bounded time for the next request and checks its buffer number.
	task automatic next_req(input logic [3:0] exp);
		int n;
		n = 0;
		do begin
			@(posedge CLK);
			n++;
		end while (REQV !== 1'b1 && n < 400);
		check({7'h0, REQV}, 8'h01);
		check({4'h0, REQB}, {4'h0, exp});
	endtask
	// Pops one history entry and checks it the cycle after the pop.
	task automatic hist_read(input logic [3:0] exp);
		@(posedge CLK) HRD <= 1'b1;
		@(posedge CLK) HRD <= 1'b0;
		@(posedge CLK);
		check({4'h0, HDATA}, {4'h0, exp});
	endtask
	// Pulses the restart bit with the trigger low and watches it rise and fall again by itself.
	task automatic restart;
		@(posedge CLK) RSET <= 1'b1;
		@(posedge CLK) RSET <= 1'b0;
		@(posedge CLK);
		check({7'h0, RST}, 8'h01);
		repeat (3) @(posedge CLK);
		check({7'h0, RST}, 8'h00);
	endtask
	// Cuts a hung run short; the tests need well under 3000 cycles.
	initial begin
		#(25 * 20000);
		num_errors++;
		test_done();
	end
	initial begin
		repeat (6) @(posedge CLK);
		RESET_N <= 1'b1;
		@(posedge CLK);
		check({HDATA, RST, REQV, EMPTY, OVF}, 8'h02);
		check({7'h0, DRDY}, 8'h01);
		$display("test reset done");
		// A short run of three buffers, stopped by dropping the trigger.
		TRIG <= 1'b1;
		for (i = 0; i < 3; i++) next_req(i[3:0]);
		TRIG <= 1'b0;
		repeat (20) @(posedge CLK);
		check({7'h0, EMPTY}, 8'h00);
		for (i = 0; i < 3; i++) hist_read(i[3:0]);
		@(posedge CLK);
		check({7'h0, EMPTY}, 8'h01);
		$display("test short run done");
		// Restart rewinds to buffer zero; ten sends overfill the list of eight, with a slow node.
		restart();
		delay <= 8'h0c;
		TRIG <= 1'b1;
		for (i = 0; i < 10; i++) next_req(i[3:0] & 4'h7);
		TRIG <= 1'b0;
		repeat (30) @(posedge CLK);
		check({7'h0, OVF}, 8'h01);
		for (i = 0; i < 8; i++) hist_read(i[3:0]);
		@(posedge CLK);
		check({6'h0, OVF, EMPTY}, 8'h03);
		$display("test overflow done");
		// A further send while overflowed leaves the empty flag set.
		delay <= 8'h00;
		TRIG <= 1'b1;
		@(posedge CLK);
		while (REQV !== 1'b1 && i < 400) @(posedge CLK) i++;
		TRIG <= 1'b0;
		repeat (20) @(posedge CLK);
		check({6'h0, OVF, EMPTY}, 8'h03);
		@(posedge CLK) OCLR <= 1'b1;
		@(posedge CLK) OCLR <= 1'b0;
		@(posedge CLK);
		check({7'h0, OVF}, 8'h00);
		$display("test overflow clear done");
		test_done();
	end
endmodule
